// *** design/pdct_consts.svh ***
`ifndef PDCT_CONSTS_SVH
`define PDCT_CONSTS_SVH

// ----------------------------------------
// register indices, byte address = 4 x index
// ----------------------------------------
`define PDCT_IDX_DB_MODE    6'h0F
`define PDCT_IDX_RISE_CNT   6'h10
`define PDCT_IDX_FALL_CNT   6'h11
`define PDCT_IDX_TRIP_SEL   6'h12
`define PDCT_IDX_TRIP_RSVD  6'h13
`define PDCT_IDX_TRIP_ACT   6'h14
`define PDCT_IDX_TRIP_IEN   6'h15
`define PDCT_IDX_TRIP_FLG   6'h16
`define PDCT_IDX_TRIP_CLR   6'h17
`define PDCT_IDX_TRIP_FRC   6'h18
`define PDCT_IDX_UNLOCK     6'h1D
`define PDCT_IDX_CHOP       6'h1E

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PDCT_SEL_CBC_LSB    0
`define PDCT_SEL_OST_LSB    8
`define PDCT_FLG_INT        0
`define PDCT_FLG_CBC        1
`define PDCT_FLG_OST        2
`define PDCT_CHP_EN         0
`define PDCT_CHP_OSW_LSB    1
`define PDCT_CHP_FRQ_LSB    5
`define PDCT_CHP_DUTY_LSB   8
`define PDCT_ACT_B_LSB      2
`define PDCT_OSW_SHIFT      3
`define PDCT_RST16          16'h0000

`endif

// *** design/pdct_pkg.sv ***
package pdct_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pdct_avs_req_s;

    typedef struct packed {
        logic a;
        logic b;
    } pdct_pair_s;

    typedef enum logic [1:0] {
        PDCT_TRIP_HIZ  = 2'b00,
        PDCT_TRIP_HIGH = 2'b01,
        PDCT_TRIP_LOW  = 2'b10,
        PDCT_TRIP_KEEP = 2'b11
    } pdct_trip_act_e;

endpackage

// *** design/pdct_edge_delay.sv ***
`timescale 1ns/1ps
module pdct_edge_delay #(
    parameter int W = 10
) (
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    input  wire logic         sig_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] count_i,
    output logic              sig_o
);
    logic [W-1:0] cnt_q;

    // rising edge waits count_i timebase ticks, falling edge passes at once
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cnt_q <= '0;
            sig_o <= 1'b0;
        end else if (!sig_i) begin
            cnt_q <= '0;
            sig_o <= 1'b0;
        end else if (!sig_o) begin
            if (cnt_q == count_i) begin
                sig_o <= 1'b1;
            end else if (tick_i) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule

// *** design/pdct_chopper.sv ***
`timescale 1ns/1ps
`include "pdct_consts.svh"
module pdct_chopper #(
    parameter int OSW = 4,
    parameter int FW  = 3,
    parameter int DW  = 3
) (
    input  wire logic           clk_sys_i,
    input  wire logic           srst_i,
    input  wire logic           sig_i,
    input  wire logic           en_i,
    input  wire logic [OSW-1:0] osw_i,
    input  wire logic [FW-1:0]  frq_i,
    input  wire logic [DW-1:0]  duty_i,
    output logic                sig_o
);
    localparam int CW = OSW + 1 + `PDCT_OSW_SHIFT;

    logic [FW-1:0] div_q;
    logic [DW-1:0] ph_q;
    logic [CW-1:0] os_q;
    logic          prev_q;

    wire           rise    = sig_i & ~prev_q;
    wire [OSW:0]   osw_p1  = {1'b0, osw_i} + {{OSW{1'b0}}, 1'b1};
    wire [CW-1:0]  os_load = {osw_p1, {`PDCT_OSW_SHIFT{1'b0}}};
    wire           first   = rise | (os_q > {{(CW-1){1'b0}}, 1'b1});
    wire           carrier = ph_q < duty_i;
    wire           div_end = div_q == frq_i;
    wire           chopped = sig_i & (first | carrier);

    // ----------------------------------------
    // carrier: eight phases of (frq+1) clocks each
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            div_q  <= '0;
            ph_q   <= '0;
            os_q   <= '0;
            prev_q <= 1'b0;
            sig_o  <= 1'b0;
        end else begin
            div_q  <= div_end ? '0 : div_q + 1'b1;
            ph_q   <= div_end ? ph_q + 1'b1 : ph_q;
            os_q   <= rise ? os_load : (os_q != '0 ? os_q - 1'b1 : os_q);
            prev_q <= sig_i;
            sig_o  <= en_i ? chopped : sig_i;
        end
    end
endmodule

// *** design/pdct_top.sv ***
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pdct_consts.svh"
// Functional notes
// - separate 10-bit rise and fall delay counts
// - edges delayed by count timebase periods
// - chopper modulates conditioned pwm with carrier
// - carrier from system clock, freq/duty fields
// - wide first pulse, then sustaining pulses
// - first pulse is 8 x (field+1) clocks
// - seven sustaining duty ratios 12.5..87.5%
// - chopper disabled passes signals unchanged
// - six active-low faults, individually mapped
// - trip forces high, low, hi-z or nothing
// - each fault latched or cycle-by-cycle
// - trip interrupt from any fault
// - software force acts like hardware fault
// - unconfigured trip leaves outputs untouched
// - trip writes ignored unless unlocked
// - cycle trip clears at zero; flag sticky
// - latched trip held until clear write
// - mode 00 no delay, 11 both delays
module pdct_top #(
    parameter int NF = 6,
    parameter int DBW = 10
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  srst_i,
    input  wire pdct_pkg::pdct_avs_req_s avs_req_i,
    output logic [31:0]                avs_readdata_o,
    output logic                       avs_waitrequest_o,
    input  wire pdct_pkg::pdct_pair_s  pwm_in_i,
    input  wire logic                  tb_tick_i,
    input  wire logic                  tb_zero_i,
    input  wire logic [NF-1:0]         fault_input_n_i,
    output logic                       pwm_output_a_o,
    output logic                       pwm_output_a_oe_n_o,
    output logic                       pwm_output_b_o,
    output logic                       pwm_output_b_oe_n_o,
    output logic                       trip_irq_o
);
    import pdct_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0]     db_mode_q;
    logic [DBW-1:0] rise_delay_count_q;
    logic [DBW-1:0] fall_delay_count_q;
    logic [15:0]    trip_source_select_q;
    logic [3:0]     trip_action_control_q;
    logic [2:0]     trip_interrupt_enable_q;
    logic           flag_int_q;
    logic           flag_cbc_q;
    logic           latched_trip_flag_q;
    logic           cbc_trip_q;
    logic           ost_trip_q;
    logic           unlock_q;
    logic [10:0]    chopper_control_q;
    logic [NF-1:0]  fault_meta_q;
    logic [NF-1:0]  fault_sync_q;

    function automatic logic [15:0] pdct_merge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    // answer one clock after the request; a write lands as waitrequest is seen low
    wire        req     = avs_req_i.read | avs_req_i.write;
    wire        acc_w   = avs_req_i.write & ~avs_waitrequest_o;
    wire [5:0]  idx     = avs_req_i.address[7:2];
    wire        aligned = avs_req_i.address[1:0] == 2'b00;
    wire [31:0] wd      = avs_req_i.writedata;
    wire [3:0]  be      = avs_req_i.byteenable;
    wire        lo_en   = be[0];

    wire hit_mode = aligned & (idx == `PDCT_IDX_DB_MODE);
    wire hit_rise = aligned & (idx == `PDCT_IDX_RISE_CNT);
    wire hit_fall = aligned & (idx == `PDCT_IDX_FALL_CNT);
    wire hit_sel  = aligned & (idx == `PDCT_IDX_TRIP_SEL);
    wire hit_act  = aligned & (idx == `PDCT_IDX_TRIP_ACT);
    wire hit_ien  = aligned & (idx == `PDCT_IDX_TRIP_IEN);
    wire hit_flg  = aligned & (idx == `PDCT_IDX_TRIP_FLG);
    wire hit_clr  = aligned & (idx == `PDCT_IDX_TRIP_CLR);
    wire hit_frc  = aligned & (idx == `PDCT_IDX_TRIP_FRC);
    wire hit_unl  = aligned & (idx == `PDCT_IDX_UNLOCK);
    wire hit_chop = aligned & (idx == `PDCT_IDX_CHOP);

    // trip registers only take writes while unlocked
    wire trip_wr = acc_w & unlock_q;
    wire wr_mode = acc_w & hit_mode;
    wire wr_rise = acc_w & hit_rise;
    wire wr_fall = acc_w & hit_fall;
    wire wr_sel  = trip_wr & hit_sel;
    wire wr_act  = trip_wr & hit_act;
    wire wr_ien  = trip_wr & hit_ien;
    wire wr_clr  = trip_wr & hit_clr & lo_en;
    wire wr_frc  = trip_wr & hit_frc & lo_en;
    wire wr_unl  = acc_w & hit_unl & lo_en;
    wire wr_chop = acc_w & hit_chop;

    wire [15:0] m_mode = pdct_merge({14'h0000, db_mode_q}, wd, be);
    wire [15:0] m_rise = pdct_merge({6'h00, rise_delay_count_q}, wd, be);
    wire [15:0] m_fall = pdct_merge({6'h00, fall_delay_count_q}, wd, be);
    wire [15:0] m_sel  = pdct_merge(trip_source_select_q, wd, be);
    wire [15:0] m_act  = pdct_merge({12'h000, trip_action_control_q}, wd, be);
    wire [15:0] m_ien  = pdct_merge({13'h0000, trip_interrupt_enable_q}, wd, be);
    wire [15:0] m_chop = pdct_merge({5'h00, chopper_control_q}, wd, be);

    // ----------------------------------------
    // fault synchronisers and trip sources
    // ----------------------------------------
    wire [NF-1:0] fault_act = ~fault_sync_q;
    wire [NF-1:0] cbc_map   = trip_source_select_q[`PDCT_SEL_CBC_LSB +: NF];
    wire [NF-1:0] ost_map   = trip_source_select_q[`PDCT_SEL_OST_LSB +: NF];

    wire cbc_src = |(fault_act & cbc_map);
    wire ost_src = |(fault_act & ost_map);

    wire frc_cbc = wr_frc & wd[`PDCT_FLG_CBC];
    wire frc_ost = wr_frc & wd[`PDCT_FLG_OST];
    wire clr_int = wr_clr & wd[`PDCT_FLG_INT];
    wire clr_cbc = wr_clr & wd[`PDCT_FLG_CBC];
    wire clr_ost = wr_clr & wd[`PDCT_FLG_OST];

    wire cbc_set = cbc_src | frc_cbc;
    wire ost_set = ost_src | frc_ost;

    // cycle trip ends at counter zero once the fault has gone
    wire cbc_trip_d = cbc_set | (cbc_trip_q & ~tb_zero_i);
    // latched trip only ends by a clear write; a new event wins
    wire ost_trip_d = ost_set | (ost_trip_q & ~clr_ost);

    // sticky flags: a set in the clearing cycle wins
    wire flag_cbc_d = cbc_set | (flag_cbc_q & ~clr_cbc);
    wire flag_ost_d = ost_set | (latched_trip_flag_q & ~clr_ost);

    wire irq_set = (cbc_set & trip_interrupt_enable_q[`PDCT_FLG_CBC]) |
                   (ost_set & trip_interrupt_enable_q[`PDCT_FLG_OST]);
    wire flag_int_d = irq_set | (flag_int_q & ~clr_int);

    wire tripped = cbc_trip_q | ost_trip_q;

    // ----------------------------------------
    // dead band
    // ----------------------------------------
    logic [1:0] dly_raw;
    logic [1:0] dly;
    wire  [DBW-1:0] dly_count [2];

    assign dly_count[0] = rise_delay_count_q;
    assign dly_count[1] = fall_delay_count_q;

    // a falling-edge delay is a rising-edge delay on the inverted signal
    for (genvar i = 0; i < 2; i++) begin : g_dly
        wire inv = (i == 1);
        pdct_edge_delay #(
            .W (DBW)
        ) u_dly (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .sig_i     (pwm_in_i.a ^ inv),
            .tick_i    (tb_tick_i),
            .count_i   (dly_count[i]),
            .sig_o     (dly_raw[i])
        );
        assign dly[i] = dly_raw[i] ^ inv;
    end

    // mode bit 1 delays the rise of a, bit 0 delays the fall into b
    wire db_a = db_mode_q[1] ? dly[0] : pwm_in_i.a;
    wire db_b = db_mode_q[0] ? dly[1] : pwm_in_i.b;

    // ----------------------------------------
    // chopper
    // ----------------------------------------
    wire       chp_en   = chopper_control_q[`PDCT_CHP_EN];
    wire [3:0] chp_osw  = chopper_control_q[`PDCT_CHP_OSW_LSB +: 4];
    wire [2:0] chp_frq  = chopper_control_q[`PDCT_CHP_FRQ_LSB +: 3];
    wire [2:0] chp_duty = chopper_control_q[`PDCT_CHP_DUTY_LSB +: 3];
    wire [1:0] chp_in   = {db_b, db_a};
    logic [1:0] chp_out;

    // one carrier per output so a and b first pulses are independent
    for (genvar i = 0; i < 2; i++) begin : g_chp
        pdct_chopper #(
            .OSW (4),
            .FW  (3),
            .DW  (3)
        ) u_chp (
            .clk_sys_i (clk_sys_i),
            .srst_i    (srst_i),
            .sig_i     (chp_in[i]),
            .en_i      (chp_en),
            .osw_i     (chp_osw),
            .frq_i     (chp_frq),
            .duty_i    (chp_duty),
            .sig_o     (chp_out[i])
        );
    end

    // ----------------------------------------
    // trip action on the pins
    // ----------------------------------------
    logic [1:0] pin_d;
    logic [1:0] oe_n_d;

    for (genvar i = 0; i < 2; i++) begin : g_trip
        wire [1:0] act_bits = trip_action_control_q[2*i +: 2];
        pdct_trip_act_e act;
        assign act = pdct_trip_act_e'(act_bits);
        // without a trip the chopper result goes straight out
        always_comb begin
            pin_d[i]  = chp_out[i];
            oe_n_d[i] = 1'b0;
            if (tripped) begin
                unique case (act)
                    PDCT_TRIP_HIZ: begin
                        pin_d[i]  = 1'b0;
                        oe_n_d[i] = 1'b1;
                    end
                    PDCT_TRIP_HIGH: pin_d[i] = 1'b1;
                    PDCT_TRIP_LOW:  pin_d[i] = 1'b0;
                    PDCT_TRIP_KEEP: pin_d[i] = chp_out[i];
                endcase
            end
        end
    end

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // reserved slot and unmapped offsets read zero
    wire [15:0] flg_val = {13'h0000, latched_trip_flag_q, flag_cbc_q, flag_int_q};
    wire [15:0] rd_mux =
        ({16{hit_mode}} & {14'h0000, db_mode_q}) |
        ({16{hit_rise}} & {6'h00, rise_delay_count_q}) |
        ({16{hit_fall}} & {6'h00, fall_delay_count_q}) |
        ({16{hit_sel}}  & trip_source_select_q) |
        ({16{hit_act}}  & {12'h000, trip_action_control_q}) |
        ({16{hit_ien}}  & {13'h0000, trip_interrupt_enable_q}) |
        ({16{hit_flg}}  & flg_val) |
        ({16{hit_unl}}  & {15'h0000, unlock_q}) |
        ({16{hit_chop}} & {5'h00, chopper_control_q});
    wire wait_d = ~(req & avs_waitrequest_o);

    // ----------------------------------------
    // configuration state
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            db_mode_q          <= 2'b00;
            rise_delay_count_q <= '0;
            fall_delay_count_q <= '0;
            unlock_q           <= 1'b0;
            chopper_control_q  <= 11'h000;
        end else begin
            if (wr_mode) db_mode_q <= m_mode[1:0];
            if (wr_rise) rise_delay_count_q <= m_rise[DBW-1:0];
            if (wr_fall) fall_delay_count_q <= m_fall[DBW-1:0];
            if (wr_unl)  unlock_q <= wd[0];
            if (wr_chop) chopper_control_q <= m_chop[10:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trip_source_select_q    <= `PDCT_RST16;
            trip_action_control_q   <= 4'h0;
            trip_interrupt_enable_q <= 3'h0;
        end else begin
            if (wr_sel) trip_source_select_q <= m_sel;
            if (wr_act) trip_action_control_q <= m_act[3:0];
            if (wr_ien) trip_interrupt_enable_q <= m_ien[2:0];
        end
    end

    // ----------------------------------------
    // trip state and synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            fault_meta_q        <= '1;
            fault_sync_q        <= '1;
            cbc_trip_q          <= 1'b0;
            ost_trip_q          <= 1'b0;
            flag_cbc_q          <= 1'b0;
            latched_trip_flag_q <= 1'b0;
            flag_int_q          <= 1'b0;
        end else begin
            fault_meta_q        <= fault_input_n_i;
            fault_sync_q        <= fault_meta_q;
            cbc_trip_q          <= cbc_trip_d;
            ost_trip_q          <= ost_trip_d;
            flag_cbc_q          <= flag_cbc_d;
            latched_trip_flag_q <= flag_ost_d;
            flag_int_q          <= flag_int_d;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pwm_output_a_o      <= 1'b0;
            pwm_output_a_oe_n_o <= 1'b0;
            pwm_output_b_o      <= 1'b0;
            pwm_output_b_oe_n_o <= 1'b0;
            trip_irq_o          <= 1'b0;
            avs_waitrequest_o   <= 1'b1;
            avs_readdata_o      <= 32'h0000_0000;
        end else begin
            pwm_output_a_o      <= pin_d[0];
            pwm_output_a_oe_n_o <= oe_n_d[0];
            pwm_output_b_o      <= pin_d[1];
            pwm_output_b_oe_n_o <= oe_n_d[1];
            trip_irq_o          <= flag_int_q;
            avs_waitrequest_o   <= wait_d;
            avs_readdata_o      <= (avs_req_i.read & avs_waitrequest_o) ? {16'h0000, rd_mux}
                                                             : avs_readdata_o;
        end
    end

endmodule

// *** tb/pdct_gate_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// gate drivers and fault sources
// ----------------------------------------
module pdct_gate_model (
    input  wire logic       pin_a_i,
    input  wire logic       oe_a_n_i,
    input  wire logic       pin_b_i,
    input  wire logic       oe_b_n_i,
    input  wire logic [5:0] fault_req_i,
    output logic            gate_a_o,
    output logic            gate_b_o,
    output logic [5:0]      fault_input_n_o
);
    // driver inputs have pull-downs: a released pin reads low
    assign gate_a_o        = oe_a_n_i ? 1'b0 : pin_a_i;
    assign gate_b_o        = oe_b_n_i ? 1'b0 : pin_b_i;
    assign fault_input_n_o = ~fault_req_i;
endmodule

// *** tb/pdct_top_checker.sv ***
`timescale 1ns/1ps
module pdct_top_checker #(
    parameter int NF  = 6,
    parameter int DBW = 10
) (
    input wire logic                    clk_sys_i,
    input wire logic                    srst_i,
    input wire pdct_pkg::pdct_avs_req_s avs_req_i,
    input wire logic [31:0]             avs_readdata_o,
    input wire logic                    avs_waitrequest_o,
    input wire pdct_pkg::pdct_pair_s    pwm_in_i,
    input wire logic                    tb_tick_i,
    input wire logic                    tb_zero_i,
    input wire logic [NF-1:0]           fault_input_n_i,
    input wire logic                    pwm_output_a_o,
    input wire logic                    pwm_output_a_oe_n_o,
    input wire logic                    pwm_output_b_o,
    input wire logic                    pwm_output_b_oe_n_o,
    input wire logic                    trip_irq_o
);
    import pdct_pkg::*;
    // ----------------------------------------
    // shadow of the settings written over the bus
    // ----------------------------------------
    logic       unl_q, cfg_q, ien_q, chop_q;
    logic [1:0] mode_q;
    logic [3:0] act_q;
    wire        wr_ok  = avs_req_i.write && !avs_waitrequest_o;
    wire        rd_ok  = avs_req_i.read && !avs_waitrequest_o;
    wire [7:0]  ad     = avs_req_i.address;
    wire [31:0] wd     = avs_req_i.writedata;
    wire        tz_wr  = wr_ok && unl_q;
    // sticky: a latched trip may outlive its mapping
    wire        bypass = !chop_q && mode_q == 2'b00 && !cfg_q;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            {unl_q, cfg_q, ien_q, chop_q, mode_q, act_q} <= '0;
        end else begin
            if (wr_ok && ad == 8'h74) unl_q <= wd[0];
            if (wr_ok && ad == 8'h78) chop_q <= wd[0];
            if (wr_ok && ad == 8'h3C) mode_q <= wd[1:0];
            if (tz_wr && ad == 8'h50) act_q <= wd[3:0];
            if (tz_wr && ad == 8'h54 && wd[2:0] != 3'h0) ien_q <= 1'b1;
            if (tz_wr && (ad == 8'h48 || ad == 8'h60) && wd[13:0] != 14'h0) cfg_q <= 1'b1;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_wait_answer: assert property (
        (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request unanswered");
    a_wait_pulse: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait low too long");
    a_rsvd_zero: assert property (
        rd_ok && (ad == 8'h4C || ad == 8'hFC || ad[1:0] != 2'b00) |-> avs_readdata_o == 32'h0)
        else $error("reserved read not zero");
    a_count_width: assert property (
        rd_ok && (ad == 8'h40 || ad == 8'h44) |-> (avs_readdata_o >> DBW) == 32'h0)
        else $error("delay count too wide");
    a_bypass_pass: assert property (
        (bypass && $stable(pwm_in_i))[*4] |-> {pwm_output_a_o, pwm_output_b_o} == pwm_in_i
        && !pwm_output_a_oe_n_o && !pwm_output_b_oe_n_o) else $error("bypass altered pins");
    a_trip_quiet: assert property (
        !cfg_q |-> !pwm_output_a_oe_n_o && !pwm_output_b_oe_n_o) else $error("pins released");
    a_hiz_a: assert property (
        pwm_output_a_oe_n_o |-> $past(act_q[1:0]) == 2'b00) else $error("pin a hi-z wrong code");
    a_hiz_b: assert property (
        pwm_output_b_oe_n_o |-> $past(act_q[3:2]) == 2'b00) else $error("pin b hi-z wrong code");
    a_irq_off: assert property (
        !ien_q |-> !trip_irq_o) else $error("irq without enable");
endmodule

bind pdct_top pdct_top_checker #(.NF(NF), .DBW(DBW)) i_chk (.clk_sys_i, .srst_i, .avs_req_i,
    .avs_readdata_o, .avs_waitrequest_o, .pwm_in_i, .tb_tick_i, .tb_zero_i, .fault_input_n_i,
    .pwm_output_a_o, .pwm_output_a_oe_n_o, .pwm_output_b_o, .pwm_output_b_oe_n_o, .trip_irq_o);

// *** tb/pwm_deadband_chopper_trip_bench.sv ***
`timescale 1ns/1ps
module pwm_deadband_chopper_trip_bench;
    import pdct_pkg::*;
    logic          clk_sys, srst, wait_req, pin_a, pin_b, oe_a_n, oe_b_n, irq, gate_a, gate_b;
    logic          tick = 1'b0;
    logic          zero;
    pdct_avs_req_s req;
    pdct_pair_s    pwm;
    logic [31:0]   rd_bus, rd_val;
    logic [5:0]    fault_req, fault_n;
    logic [7:0]    ra [8] = '{8'h3C, 8'h40, 8'h44, 8'h48, 8'h50, 8'h54, 8'h58, 8'h78};
    int            error_cnt, checks, cyc, n, hi;

    pdct_top #(.NF(6), .DBW(10)) i_dut (.clk_sys_i(clk_sys), .srst_i(srst), .avs_req_i(req),
        .avs_readdata_o(rd_bus), .avs_waitrequest_o(wait_req), .pwm_in_i(pwm), .tb_tick_i(tick),
        .tb_zero_i(zero), .fault_input_n_i(fault_n), .pwm_output_a_o(pin_a),
        .pwm_output_a_oe_n_o(oe_a_n), .pwm_output_b_o(pin_b), .pwm_output_b_oe_n_o(oe_b_n),
        .trip_irq_o(irq));
    pdct_gate_model i_gate (.pin_a_i(pin_a), .oe_a_n_i(oe_a_n), .pin_b_i(pin_b),
        .oe_b_n_i(oe_b_n), .fault_req_i(fault_req), .gate_a_o(gate_a), .gate_b_o(gate_b),
        .fault_input_n_o(fault_n));

    // ----------------------------------------
    // clock, timebase tick, watchdog
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // one timebase tick every second clock
    always @(posedge clk_sys) tick <= ~tick;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        req <= '{!wr, wr, ad, wd, 4'hF};
        @(posedge clk_sys);
        while (wait_req !== 1'b0) @(posedge clk_sys);
        rd_val = rd_bus;
        req <= '0;
        // idle edge between requests
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        bus(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        bus(1'b0, ad, 32'h0);
        check(rd_val, exp);
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic pins(input logic ea, input logic eb, input logic eoe, input logic eirq);
        check({27'h0, gate_a, gate_b, oe_a_n, oe_b_n, irq}, {27'h0, ea, eb, eoe, eoe, eirq});
    endtask
    task automatic lvl(input logic use_b, input logic want);
        n = 0;
        while (((use_b ? gate_b : gate_a) !== want) && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        srst <= 1'b1;
        req <= '0;
        pwm <= '0;
        zero <= 1'b0;
        fault_req <= '0;
        step(16);
        srst <= 1'b0;
        step(1);
        pins(1'b0, 1'b0, 1'b0, 1'b0);
        foreach (ra[i]) rd(ra[i], 32'h0);
        wr(8'h40, 32'hFFFF);
        rd(8'h40, 32'h3FF);
        wr(8'h40, 32'h5);
        wr(8'h44, 32'hC);
        rd(8'h44, 32'hC);
        wr(8'h3C, 32'h3);
        step(40);
        pwm.a <= 1'b1;
        lvl(1'b0, 1'b1);
        check(32'(n >= 10 && n <= 16), 32'h1);
        step(40);
        pwm.a <= 1'b0;
        lvl(1'b1, 1'b0);
        check(32'(n >= 24 && n <= 30), 32'h1);
        wr(8'h3C, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(8'h78, 32'h5 | (k % 2) << 5 | (k << 8));
            step(8);
            pwm.a <= 1'b1;
            lvl(1'b0, 1'b1);
            lvl(1'b0, 1'b0);
            check(32'(n >= 24 && n <= 24 + k * (k % 2 + 1)), 32'h1);
            if (k > 0) begin
                lvl(1'b0, 1'b1);
                lvl(1'b0, 1'b0);
                check(n, k * (k % 2 + 1));
            end
            hi = 0;
            repeat (64) begin
                @(posedge clk_sys);
                hi += gate_a;
            end
            check(hi, 8 * k);
            pwm.a <= 1'b0;
            step(4);
        end
        wr(8'h78, 32'h0);
        pwm.a <= 1'b1;
        step(6);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        wr(8'h48, 32'h101);
        rd(8'h48, 32'h0);
        wr(8'h74, 32'h1);
        wr(8'h48, 32'h100);
        rd(8'h48, 32'h100);
        wr(8'h4C, 32'hFFFF);
        rd(8'h4C, 32'h0);
        rd(8'hFC, 32'h0);
        rd(8'h49, 32'h0);
        for (int j = 0; j < 4; j++) begin
            wr(8'h50, j | (j << 2));
            fault_req <= 6'h01;
            step(6);
            pins(j == 1 || j == 3, j == 1, j == 0, 1'b0);
            fault_req <= 6'h00;
            step(6);
            pins(j == 1 || j == 3, j == 1, j == 0, 1'b0);
            rd(8'h58, 32'h4);
            wr(8'h5C, 32'h4);
            step(4);
            pins(1'b1, 1'b0, 1'b0, 1'b0);
        end
        wr(8'h50, 32'hA);
        wr(8'h54, 32'h2);
        for (int i = 0; i < 6; i++) begin
            wr(8'h48, 32'h1 << i);
            fault_req <= 6'h1 << ((i + 1) % 6);
            step(6);
            pins(1'b1, 1'b0, 1'b0, 1'b0);
            fault_req <= 6'h1 << i;
            step(6);
            pins(1'b0, 1'b0, 1'b0, 1'b1);
            fault_req <= 6'h0;
            step(6);
            pins(1'b0, 1'b0, 1'b0, 1'b1);
            zero <= 1'b1;
            step(1);
            zero <= 1'b0;
            step(6);
            pins(1'b1, 1'b0, 1'b0, 1'b1);
            rd(8'h58, 32'h3);
            wr(8'h5C, 32'h7);
            rd(8'h58, 32'h0);
            pins(1'b1, 1'b0, 1'b0, 1'b0);
        end
        wr(8'h50, 32'h5);
        wr(8'h54, 32'h0);
        wr(8'h60, 32'h4);
        step(6);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        rd(8'h58, 32'h4);
        wr(8'h5C, 32'h4);
        step(4);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        wr(8'h74, 32'h0);
        wr(8'h48, 32'h3F);
        rd(8'h48, 32'h20);
        end_sim();
    end
endmodule
